// ===== design/link_group_irq_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_consts.svh"

module link_group_irq_status (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire irq_pkg::host_req_t HOST_REQ_IN,
    input wire irq_pkg::link_evt_t [7:0] LINK_EVT_IN,
    input wire logic [7:0] LINK_CNT_OVF_IN,
    input wire logic [3:0] ICP_READY_IN,
    input wire logic [3:0] FRAME_PULSE_IN,
    input wire logic [3:0] GRP_OVF_EVT_IN,
    output logic [7:0] RDATA_OUT,
    output logic IRQ_N_OUT
);
    import irq_pkg::*;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // returns {hit, index} for an eight-register window at base
    function automatic logic [3:0] decode_link(
        input logic [9:0] a,
        input logic [9:0] base
    );
        logic [9:0] d;
        d = a - base;
        decode_link = {(a >= base) && (d < `LINK_SPAN), d[2:0]};
    endfunction : decode_link

    logic [3:0] sel_stat;
    logic [3:0] sel_en;
    logic hit_men;
    logic hit_mstat;
    logic hit_grp;

    always_comb
    begin
        sel_stat = decode_link(HOST_REQ_IN.addr, `LINK_STAT_BASE);
        sel_en = decode_link(HOST_REQ_IN.addr, `LINK_EN_BASE);
        hit_men = HOST_REQ_IN.addr == `MASTER_EN_ADDR;
        hit_mstat = HOST_REQ_IN.addr == `MASTER_STAT_ADDR;
        hit_grp = HOST_REQ_IN.addr == `GRP_OVF_ADDR;
    end

    // ----------------------------------------
    // group level sources
    // ----------------------------------------
    logic [3:0] icp_ready_q;
    logic [3:0] grp_q;
    logic icp_xfer;
    logic grp_any;

    // ready bits come from core logic, so no synchroniser is needed
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            icp_ready_q <= 4'hf;
        else
            icp_ready_q <= ICP_READY_IN;
    end

    // reset to all ones so a ready bit high at reset is no false event
    always_comb
    begin
        icp_xfer = |(ICP_READY_IN & ~icp_ready_q) | (|FRAME_PULSE_IN);
        grp_any = |grp_q;
    end

    // host write of 0 clears, a same-cycle overflow still sets
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            grp_q <= `GRP_OVF_RST;
        else if (HOST_REQ_IN.wr && hit_grp)
            grp_q <= (grp_q & HOST_REQ_IN.wdata[3:0]) | GRP_OVF_EVT_IN;
        else
            grp_q <= grp_q | GRP_OVF_EVT_IN;
    end

    // ----------------------------------------
    // per-link status and enable
    // ----------------------------------------
    logic [7:0] stat [8];
    logic [7:0] en [8];
    logic [7:0] link_req;

    genvar g;
    generate
        for (g = 0; g < `LINK_COUNT; g++)
        begin : gen_link
            link_status_cell #(
                .IS_LINK0(g == 0)
            ) u_cell (
                .clk_in(CORE_CLK_IN),
                .rst_in(RST_IN),
                .wr_stat_in(HOST_REQ_IN.wr && sel_stat[3]
                    && sel_stat[2:0] == 3'(g)),
                .wr_en_in(HOST_REQ_IN.wr && sel_en[3]
                    && sel_en[2:0] == 3'(g)),
                .wdata_in(HOST_REQ_IN.wdata),
                .evt_in(LINK_EVT_IN[g]),
                .grp_any_in(grp_any),
                .icp_xfer_in(icp_xfer),
                .cnt_ovf_in(LINK_CNT_OVF_IN[g]),
                .status_out(stat[g]),
                .enable_out(en[g]),
                .req_out(link_req[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // master stage
    // ----------------------------------------
    logic [7:0] men_q;
    logic irq_n_q;

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            men_q <= `MASTER_EN_RST;
        else if (HOST_REQ_IN.wr && hit_men)
            men_q <= HOST_REQ_IN.wdata;
    end

    // pin is registered: one cycle behind the request, free of glitches
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            irq_n_q <= 1'b1;
        else
            irq_n_q <= ~|(link_req & men_q);
    end

    assign IRQ_N_OUT = irq_n_q;

    // ----------------------------------------
    // read port
    // ----------------------------------------
    logic [7:0] rd_mux;
    logic [7:0] rdata_q;

    always_comb
    begin
        rd_mux = `UNMAPPED_READ;
        if (sel_stat[3])
            rd_mux = stat[sel_stat[2:0]];
        else if (sel_en[3])
            rd_mux = en[sel_en[2:0]];
        else if (hit_men)
            rd_mux = men_q;
        else if (hit_mstat)
            rd_mux = link_req;
        else if (hit_grp)
            rd_mux = {4'h0, grp_q};
    end

    // data holds until the next read
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            rdata_q <= `RDATA_RST;
        else if (HOST_REQ_IN.rd)
            rdata_q <= rd_mux;
    end

    assign RDATA_OUT = rdata_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    logic wr_stat0;
    logic wr_en0;
    logic rd_hi_link;

    always_comb
    begin
        wr_stat0 = HOST_REQ_IN.wr && sel_stat == 4'h8;
        wr_en0 = HOST_REQ_IN.wr && sel_en == 4'h8;
        rd_hi_link = HOST_REQ_IN.rd && sel_stat[3] && sel_stat[2:0] != 3'h0;
    end

    irq_pin_a: assert property (
        ##1 IRQ_N_OUT == !$past(|(link_req & men_q)))
        else $error("interrupt pin does not follow masked requests");

    master_view_a: assert property (
        HOST_REQ_IN.rd && hit_mstat
        |=> RDATA_OUT == $past(link_req))
        else $error("master status read differs from link requests");

    master_nowr_a: assert property (
        HOST_REQ_IN.wr && hit_mstat && !HOST_REQ_IN.rd
        |=> $stable(men_q))
        else $error("master status write changed state");

    link_req_a: assert property (
        link_req[0] == |(stat[0] & en[0]))
        else $error("link request is not masked status");

    hi_bits_zero_a: assert property (
        rd_hi_link |=> RDATA_OUT[7:6] == 2'b00)
        else $error("bits 7:6 of a link 1-7 status read set");

    grp_any_a: assert property (
        GRP_OVF_EVT_IN != 4'h0 |=> stat[0][7])
        else $error("group overflow not shown in link 0 bit 7");

    grp_set_a: assert property (
        GRP_OVF_EVT_IN[2] |=> grp_q[2] ##0 stat[0][7])
        else $error("group overflow flag not set");

    icp_xfer_a: assert property (
        $rose(ICP_READY_IN[1]) && !$past(RST_IN) |=> stat[0][6])
        else $error("ready return did not set bit 6");

    frame_set_a: assert property (
        LINK_EVT_IN[0].frame_lost_flag && wr_stat0
        && !HOST_REQ_IN.wdata[2] |=> stat[0][2])
        else $error("frame loss lost against clear");

    delin_clr_a: assert property (
        wr_stat0 && !HOST_REQ_IN.wdata[1]
        && !LINK_EVT_IN[0].cell_delineation_lost_flag |=> !stat[0][1])
        else $error("write of 0 did not clear bit 1");

    sticky_hold_a: assert property (
        stat[0][3] && !wr_stat0 |=> stat[0][3])
        else $error("delay sync flag dropped without clear");

    viol_set_a: assert property (
        LINK_EVT_IN[3].protocol_violation_flag |=> stat[3][4])
        else $error("protocol violation not latched");

    icp_change_a: assert property (
        LINK_EVT_IN[5].icp_change |=> stat[5][5])
        else $error("changed ICP cell not latched");

    cnt_ovf_a: assert property (
        stat[6][0] == LINK_CNT_OVF_IN[6])
        else $error("counter overflow bit not live");

    en_store_a: assert property (
        wr_en0 |=> en[0] == $past(HOST_REQ_IN.wdata))
        else $error("enable register not stored");

    en_last_a: assert property (
        HOST_REQ_IN.wr && sel_en == 4'hf
        |=> en[7] == $past(HOST_REQ_IN.wdata))
        else $error("last enable register not stored");

    stat_view_a: assert property (
        HOST_REQ_IN.rd && sel_stat == 4'hb
        |=> RDATA_OUT == $past(stat[3]))
        else $error("link 3 status read differs from register");

    unmapped_rd_a: assert property (
        HOST_REQ_IN.rd && HOST_REQ_IN.addr == 10'h221
        |=> RDATA_OUT == 8'h00)
        else $error("unmapped read returned data");

    grp_read_a: assert property (
        HOST_REQ_IN.rd && hit_grp |=> RDATA_OUT == {4'h0, $past(grp_q)})
        else $error("group overflow read differs from flags");

    hi_icp_zero_a: assert property (
        stat[1][6] == 1'b0 && stat[7][6] == 1'b0)
        else $error("bit 6 of a link 1-7 status set");

    link7_req_a: assert property (
        link_req[7] == |(stat[7] & en[7]))
        else $error("link 7 request is not masked status");

    irq_assert_c: cover property (
        LINK_EVT_IN[0].frame_lost_flag ##1 1'b1 ##1 !IRQ_N_OUT);
    clear_irq_c: cover property (
        !IRQ_N_OUT ##1 wr_stat0 ##2 IRQ_N_OUT);
    grp_chain_c: cover property (
        GRP_OVF_EVT_IN[3] ##1 HOST_REQ_IN.rd && hit_grp);
    hi_read_c: cover property (rd_hi_link);
    set_wins_c: cover property (
        LINK_EVT_IN[0].frame_lost_flag && wr_stat0);

endmodule : link_group_irq_status
`default_nettype wire

// ===== design/irq_consts.svh
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MASTER_EN_ADDR 10'h218
`define LINK_EN_BASE 10'h219
`define LINK_STAT_BASE 10'h222
`define MASTER_STAT_ADDR 10'h232
`define GRP_OVF_ADDR 10'h235

// ----------------------------------------
// field positions and sizes
// ----------------------------------------
`define STAT_GRP_ANY_BIT 7
`define STAT_ICP_XFER_BIT 6
`define STAT_CNT_OVF_BIT 0
`define LINK_SPAN 10'h008
`define LINK_COUNT 8
`define GROUP_COUNT 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define MASTER_EN_RST 8'h00
`define LINK_EN_RST 8'h00
`define LINK_STAT_RST 8'h00
`define GRP_OVF_RST 4'h0
`define RDATA_RST 8'h00
`define UNMAPPED_READ 8'h00

`endif

// ===== design/irq_pkg.sv
package irq_pkg;

    // one host register access, synchronous to the core clock
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // one-cycle event pulses raised by a single link
    typedef struct packed {
        logic icp_change;
        logic protocol_violation_flag;
        logic delay_sync_lost_flag;
        logic frame_lost_flag;
        logic cell_delineation_lost_flag;
    } link_evt_t;

endpackage : irq_pkg

// ===== design/link_status_cell.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_consts.svh"

module link_status_cell #(
    parameter bit IS_LINK0 = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_stat_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wdata_in,
    input wire irq_pkg::link_evt_t evt_in,
    input wire logic grp_any_in,
    input wire logic icp_xfer_in,
    input wire logic cnt_ovf_in,
    output logic [7:0] status_out,
    output logic [7:0] enable_out,
    output logic req_out
);
    import irq_pkg::*;

    logic [6:1] sticky_q;
    logic [6:1] set_d;
    logic [6:1] clr_d;
    logic [7:0] en_q;

    // ----------------------------------------
    // sticky event flags
    // ----------------------------------------
    always_comb
    begin
        set_d[1] = evt_in.cell_delineation_lost_flag;
        set_d[2] = evt_in.frame_lost_flag;
        set_d[3] = evt_in.delay_sync_lost_flag;
        set_d[4] = evt_in.protocol_violation_flag;
        set_d[5] = evt_in.icp_change;
        set_d[6] = IS_LINK0 ? icp_xfer_in : 1'b0;
        clr_d = wr_stat_in ? ~wdata_in[6:1] : 6'h00;
    end

    // a write of 1 leaves a flag alone; an event in the clear cycle wins
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            sticky_q <= 6'h00;
        else
            sticky_q <= (sticky_q & ~clr_d) | set_d;
    end

    // ----------------------------------------
    // enable register
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            en_q <= `LINK_EN_RST;
        else if (wr_en_in)
            en_q <= wdata_in;
    end

    // ----------------------------------------
    // read view and request
    // ----------------------------------------
    // bit 7 (link 0 only, tied 0 on links 1-7) and bit 0 are live levels: only their sources can clear them
    always_comb
    begin
        status_out = {IS_LINK0 ? grp_any_in : 1'b0, sticky_q, cnt_ovf_in};
        enable_out = en_q;
        req_out = |(status_out & en_q);
    end

endmodule : link_status_cell
`default_nettype wire

// ===== sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host processor on the register port
// ----------------------------------------
module host_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output var irq_pkg::host_req_t req_out
);
    import irq_pkg::*;
    initial req_out = '0;
    // released bus flips, so a stale address never looks valid
    task automatic idle();
        req_out <= '{1'b0, 1'b0, ~req_out.addr, ~req_out.wdata};
    endtask : idle
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{1'b1, 1'b0, a, d};
        @(posedge clk_in);
        idle();
    endtask : wr_reg
    task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{1'b0, 1'b1, a, ~req_out.wdata};
        @(posedge clk_in);
        idle();
        #1;
        d = rdata_in;
    endtask : rd_reg
endmodule : host_model
`default_nettype wire

// ===== sim/test_link_group_irq_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_consts.svh"
module test_link_group_irq_status;
    import irq_pkg::*;
    logic clk;
    logic rst;
    host_req_t req;
    link_evt_t [7:0] evt;
    logic [7:0] cnt_ovf;
    logic [7:0] rdata;
    logic [3:0] icp_rdy;
    logic [3:0] frame;
    logic [3:0] grp_ovf;
    logic irq_n;
    int bad_count;
    int compares;
    host_model host_u (.clk_in(clk), .rdata_in(rdata), .req_out(req));
    link_group_irq_status dut_u (
        .CORE_CLK_IN(clk),
        .RST_IN(rst),
        .HOST_REQ_IN(req),
        .LINK_EVT_IN(evt),
        .LINK_CNT_OVF_IN(cnt_ovf),
        .ICP_READY_IN(icp_rdy),
        .FRAME_PULSE_IN(frame),
        .GRP_OVF_EVT_IN(grp_ovf),
        .RDATA_OUT(rdata),
        .IRQ_N_OUT(irq_n)
    );
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_sim();
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic rc(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_u.rd_reg(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask : rc
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host_u.wr_reg(a, d);
    endtask : wr
    task automatic pulse(input int l, input link_evt_t e);
        @(posedge clk);
        evt[l] <= e;
        @(posedge clk);
        evt[l] <= '0;
    endtask : pulse
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_n", {7'h00, e}, {7'h00, irq_n});
    endtask : irq_chk
    // watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        evt = '0;
        cnt_ovf = 8'h00;
        icp_rdy = 4'h0;
        frame = 4'h0;
        grp_ovf = 4'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        irq_chk(1'b1);
        for (int l = 0; l < 8; l++)
        begin
            rc(`LINK_EN_BASE + 10'(l), `LINK_EN_RST);
            rc(`LINK_STAT_BASE + 10'(l), `LINK_STAT_RST);
            wr(`LINK_EN_BASE + 10'(l), 8'ha5 ^ 8'(l));
        end
        rc(`MASTER_STAT_ADDR, 8'h00);
        rc(`GRP_OVF_ADDR, 8'h00);
        wr(10'h221, 8'hff);
        rc(10'h221, 8'h00);
        for (int l = 0; l < 8; l++)
        begin
            rc(`LINK_EN_BASE + 10'(l), 8'ha5 ^ 8'(l));
            pulse(l, '1);
            rc(`LINK_STAT_BASE + 10'(l), 8'h3e);
        end
        wr(`LINK_STAT_BASE + 10'h003, 8'hfb);
        rc(`LINK_STAT_BASE + 10'h003, 8'h3a);
        for (int l = 0; l < 8; l++)
        begin
            wr(`LINK_STAT_BASE + 10'(l), 8'h00);
            rc(`LINK_STAT_BASE + 10'(l), 8'h00);
        end
        @(posedge clk);
        cnt_ovf <= 8'h08;
        wr(`LINK_STAT_BASE + 10'h003, 8'h00);
        rc(`LINK_STAT_BASE + 10'h003, 8'h01);
        @(posedge clk);
        cnt_ovf <= 8'h00;
        rc(`LINK_STAT_BASE + 10'h003, 8'h00);
        @(posedge clk);
        grp_ovf <= 4'h4;
        @(posedge clk);
        grp_ovf <= 4'h0;
        rc(`GRP_OVF_ADDR, 8'h04);
        rc(`LINK_STAT_BASE + 10'h001, 8'h00);
        wr(`LINK_STAT_BASE, 8'h00);
        rc(`LINK_STAT_BASE, 8'h80);
        wr(`GRP_OVF_ADDR, 8'hff);
        rc(`GRP_OVF_ADDR, 8'h04);
        wr(`GRP_OVF_ADDR, 8'h00);
        rc(`LINK_STAT_BASE, 8'h00);
        @(posedge clk);
        icp_rdy <= 4'ha;
        rc(`LINK_STAT_BASE, 8'h40);
        rc(`LINK_STAT_BASE + 10'h001, 8'h00);
        wr(`LINK_STAT_BASE, 8'h00);
        rc(`LINK_STAT_BASE, 8'h00);
        @(posedge clk);
        frame <= 4'h1;
        @(posedge clk);
        frame <= 4'h0;
        rc(`LINK_STAT_BASE, 8'h40);
        wr(`LINK_STAT_BASE, 8'h00);
        fork
            wr(`LINK_STAT_BASE, 8'h00);
            pulse(0, '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
        join
        rc(`LINK_STAT_BASE, 8'h04);
        wr(`LINK_STAT_BASE, 8'h00);
        wr(`LINK_EN_BASE + 10'h005, 8'h02);
        pulse(5, '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
        rc(`LINK_STAT_BASE + 10'h005, 8'h04);
        rc(`MASTER_STAT_ADDR, 8'h00);
        wr(`LINK_EN_BASE + 10'h005, 8'h04);
        rc(`MASTER_STAT_ADDR, 8'h20);
        irq_chk(1'b1);
        wr(`MASTER_STAT_ADDR, 8'h00);
        rc(`MASTER_STAT_ADDR, 8'h20);
        wr(`MASTER_EN_ADDR, 8'h20);
        irq_chk(1'b0);
        rc(`MASTER_EN_ADDR, 8'h20);
        wr(`LINK_STAT_BASE + 10'h005, 8'h00);
        irq_chk(1'b1);
        rc(`MASTER_STAT_ADDR, 8'h00);
        end_sim();
    end
endmodule : test_link_group_irq_status
`default_nettype wire
